/* File: rtl/ilo_exec_defines.svh */
`ifndef ILO_EXEC_DEFINES_SVH
`define ILO_EXEC_DEFINES_SVH

// Register map of the software port
`define REG_CFG        4'h0
`define REG_WREG       4'h1
`define REG_STATUS     4'h2
`define REG_BANK       4'h3
`define REG_SFP_LO     4'h4
`define REG_SFP_HI     4'h5
`define REG_PTR_LO     4'h6
`define REG_PTR_HI     4'h7
`define REG_MEM_DATA   4'h8
`define REG_PHASE      4'h9

// Reset values and writable masks
`define CFG_RST        8'h00
`define CFG_MASK       8'h01
`define CFG_EXT_BIT    0
`define STATUS_MASK    8'h1f
`define BANK_MASK      8'h0f
`define HI_NIB_MASK    8'h0f

// Status flag positions
`define ST_C           0
`define ST_DC          1
`define ST_Z           2
`define ST_OV          3
`define ST_N           4

// Opcode fields
`define OPC_ADD        6'h09
`define OPC_BSET       4'h8
`define OPC_FILL       7'h34
`define D_BIT          9
`define A_BIT          8

// Addressing constants
`define IDX_LIMIT      8'h5f
`define ACC_HIGH_BANK  4'hf
`define FILL_VALUE     8'hff
`define MEM_DEPTH      4096
`define INSTR_PHASES   4

`endif

/* File: rtl/ilo_exec_pkg.sv */
package ilo_exec_pkg;

	typedef enum logic [4:0] {
		PH_IDLE   = 5'h01,
		PH_DECODE = 5'h02,
		PH_READ   = 5'h04,
		PH_PROC   = 5'h08,
		PH_WRITE  = 5'h10
	} phase_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'h1,
		OP_ADD  = 4'h2,
		OP_BSET = 4'h4,
		OP_FILL = 4'h8
	} op_t;

	typedef struct packed {
		phase_t      phase;
		op_t         op;
		logic [15:0] instr;
		logic [11:0] ea;
		logic        indexed;
		logic [7:0]  operand;
		logic [7:0]  result;
		logic [7:0]  flags;
		logic [7:0]  cfg;
		logic [7:0]  wreg;
		logic [7:0]  status;
		logic [7:0]  bank;
		logic [11:0] sfp;
		logic [11:0] mptr;
		logic [7:0]  rdata;
		logic        ready;
		logic        done;
	} exec_state_t;

	typedef struct packed {
		logic [7:0] rdata;
	} ram_state_t;

endpackage

/* File: rtl/byte_ram.sv */
`timescale 1ns/1ps
`include "ilo_exec_defines.svh"

module byte_ram (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [11:0] addr_in,
	input  wire logic        we_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [7:0]  rdata_out
);
	logic [7:0]               mem [0:`MEM_DEPTH-1];
	ilo_exec_pkg::ram_state_t st_ff;
	ilo_exec_pkg::ram_state_t nxt_st;

	// Read returns the old byte on a same-cycle write
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = mem[addr_in];
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Array kept out of reset to stay a plain RAM
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	assign rdata_out = st_ff.rdata;
endmodule

/* File: rtl/exec_alu.sv */
`timescale 1ns/1ps
`include "ilo_exec_defines.svh"

module exec_alu (
	input  wire logic             [3:0] op_in,
	input  wire logic             [7:0] wreg_in,
	input  wire logic             [7:0] operand_in,
	input  wire logic             [2:0] bit_in,
	input  wire logic             [7:0] status_in,
	output logic                  [7:0] result_out,
	output logic                  [7:0] status_out
);
	logic [8:0] sum;
	logic [4:0] low_sum;

	// Result and flags for each operation
	always_comb begin
		sum = {1'b0, wreg_in} + {1'b0, operand_in};
		low_sum = {1'b0, wreg_in[3:0]} + {1'b0, operand_in[3:0]};
		status_out = status_in;
		result_out = operand_in;
		if (op_in == ilo_exec_pkg::OP_ADD) begin
			result_out = sum[7:0];
			status_out[`ST_C] = sum[8];
			status_out[`ST_DC] = low_sum[4];
			status_out[`ST_Z] = (sum[7:0] == 8'h00);
			status_out[`ST_OV] = (wreg_in[7] == operand_in[7]) && (sum[7] != wreg_in[7]);
			status_out[`ST_N] = sum[7];
		end else if (op_in == ilo_exec_pkg::OP_BSET) begin
			result_out = operand_in | (8'h01 << bit_in);
		end else if (op_in == ilo_exec_pkg::OP_FILL) begin
			result_out = `FILL_VALUE;
		end
	end
endmodule

/* File: rtl/indexed_literal_offset_exec.sv */
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ilo_exec_defines.svh"

// Operation
// - Extension on, a=0, f<=5Fh: pointer offset
// - Otherwise operand is literal access or bank
// - Add accumulator to byte at pointer plus k
// - d=0 sum to accumulator, d=1 to byte
// - Add sets N OV C DC Z; others none
// - Add decodes as 0010 01d0 kkkk kkkk
// - Bit set touches only bit b
// - Bit set decodes as 1000 bbb0 kkkk kkkk
// - Fill writes FFh to pointer plus k
// - Fill decodes as 0110 1000 kkkk kkkk
// - Enable bit 0 disables extension, 1 enables
module indexed_literal_offset_exec (
	input  wire logic        CLK_SYS_IN,
	input  wire logic        RESET_IN,
	input  wire logic [15:0] INSTR_IN,
	input  wire logic        INSTR_VALID_IN,
	input  wire logic [3:0]  REG_ADDR_IN,
	input  wire logic [7:0]  REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [7:0]  REG_RDATA_OUT,
	output logic             INSTR_READY_OUT,
	output logic             DONE_OUT,
	output logic      [7:0]  W_OUT,
	output logic      [7:0]  STATUS_OUT,
	output logic             EXT_ENABLE_OUT
);
	localparam ilo_exec_pkg::exec_state_t ST_RST = '{
		phase:   ilo_exec_pkg::PH_IDLE,
		op:      ilo_exec_pkg::OP_NONE,
		cfg:     `CFG_RST,
		ready:   1'b1,
		default: '0
	};

	ilo_exec_pkg::exec_state_t st_ff;
	ilo_exec_pkg::exec_state_t nxt_st;
	logic                      ext_en;
	logic [11:0]               mem_addr;
	logic                      mem_we;
	logic [7:0]                mem_wdata;
	logic [7:0]                mem_rdata;
	logic [7:0]                alu_result;
	logic [7:0]                alu_status;
	logic                      write_mem;

	// Opcode to operation; unknown words run as no-ops
	function automatic ilo_exec_pkg::op_t decode_op(input logic [15:0] instr);
		if (instr[15:10] == `OPC_ADD) begin
			decode_op = ilo_exec_pkg::OP_ADD;
		end else if (instr[15:12] == `OPC_BSET) begin
			decode_op = ilo_exec_pkg::OP_BSET;
		end else if (instr[15:9] == `OPC_FILL) begin
			decode_op = ilo_exec_pkg::OP_FILL;
		end else begin
			decode_op = ilo_exec_pkg::OP_NONE;
		end
	endfunction

	// Indexed only with extension on, access bit clear, small argument
	function automatic logic is_indexed(input logic [15:0] instr, input logic ext);
		is_indexed = ext && !instr[`A_BIT] && (instr[7:0] <= `IDX_LIMIT);
	endfunction

	// Data address for the operand field
	function automatic logic [11:0] eff_addr(
		input logic [15:0] instr,
		input logic        ext,
		input logic [11:0] sfp,
		input logic [7:0]  bank
	);
		if (is_indexed(instr, ext)) begin
			eff_addr = sfp + {4'h0, instr[7:0]};
		end else if (instr[`A_BIT]) begin
			eff_addr = {bank[3:0], instr[7:0]};
		end else if (instr[7:0] <= `IDX_LIMIT) begin
			eff_addr = {4'h0, instr[7:0]};
		end else begin
			eff_addr = {`ACC_HIGH_BANK, instr[7:0]};
		end
	endfunction

	assign ext_en = st_ff.cfg[`CFG_EXT_BIT];

	// Byte store for the data space
	byte_ram u_ram (
		.clk_in    (CLK_SYS_IN),
		.reset_in  (RESET_IN),
		.addr_in   (mem_addr),
		.we_in     (mem_we),
		.wdata_in  (mem_wdata),
		.rdata_out (mem_rdata)
	);

	// Arithmetic and bit operations on the fetched byte
	exec_alu u_alu (
		.op_in      (st_ff.op),
		.wreg_in    (st_ff.wreg),
		.operand_in (mem_rdata),
		.bit_in     (st_ff.instr[11:9]),
		.status_in  (st_ff.status),
		.result_out (alu_result),
		.status_out (alu_status)
	);

	// Add with d=0 and unknown words (no-ops) are the only operations that spare the byte
	assign write_mem = (st_ff.op != ilo_exec_pkg::OP_NONE) &&
		!(st_ff.op == ilo_exec_pkg::OP_ADD && !st_ff.instr[`D_BIT]);

	// Memory port: execution owns it in the read and write phases
	always_comb begin
		mem_addr = st_ff.mptr;
		mem_we = 1'b0;
		mem_wdata = REG_WDATA_IN;
		if (st_ff.phase == ilo_exec_pkg::PH_READ || st_ff.phase == ilo_exec_pkg::PH_WRITE) begin
			mem_addr = st_ff.ea;
		end
		if (st_ff.phase == ilo_exec_pkg::PH_WRITE && write_mem) begin
			mem_we = 1'b1;
			mem_wdata = st_ff.result;
		end else if (st_ff.phase == ilo_exec_pkg::PH_IDLE && REG_WR_IN &&
			REG_ADDR_IN == `REG_MEM_DATA) begin
			mem_we = 1'b1;
		end
	end

	// Next state: software port first, execution overrides it
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.rdata = 8'h00;
		if (REG_WR_IN) begin
			if (REG_ADDR_IN == `REG_CFG) begin
				nxt_st.cfg = REG_WDATA_IN & `CFG_MASK;
			end else if (REG_ADDR_IN == `REG_WREG) begin
				nxt_st.wreg = REG_WDATA_IN;
			end else if (REG_ADDR_IN == `REG_STATUS) begin
				nxt_st.status = REG_WDATA_IN & `STATUS_MASK;
			end else if (REG_ADDR_IN == `REG_BANK) begin
				nxt_st.bank = REG_WDATA_IN & `BANK_MASK;
			end else if (REG_ADDR_IN == `REG_SFP_LO) begin
				nxt_st.sfp[7:0] = REG_WDATA_IN;
			end else if (REG_ADDR_IN == `REG_SFP_HI) begin
				nxt_st.sfp[11:8] = REG_WDATA_IN[3:0];
			end else if (REG_ADDR_IN == `REG_PTR_LO) begin
				nxt_st.mptr[7:0] = REG_WDATA_IN;
			end else if (REG_ADDR_IN == `REG_PTR_HI) begin
				nxt_st.mptr[11:8] = REG_WDATA_IN[3:0];
			end
		end
		// Read data stands one cycle, zero otherwise
		if (REG_RD_IN) begin
			if (REG_ADDR_IN == `REG_CFG) begin
				nxt_st.rdata = st_ff.cfg;
			end else if (REG_ADDR_IN == `REG_WREG) begin
				nxt_st.rdata = st_ff.wreg;
			end else if (REG_ADDR_IN == `REG_STATUS) begin
				nxt_st.rdata = st_ff.status;
			end else if (REG_ADDR_IN == `REG_BANK) begin
				nxt_st.rdata = st_ff.bank;
			end else if (REG_ADDR_IN == `REG_SFP_LO) begin
				nxt_st.rdata = st_ff.sfp[7:0];
			end else if (REG_ADDR_IN == `REG_SFP_HI) begin
				nxt_st.rdata = {4'h0, st_ff.sfp[11:8]};
			end else if (REG_ADDR_IN == `REG_PTR_LO) begin
				nxt_st.rdata = st_ff.mptr[7:0];
			end else if (REG_ADDR_IN == `REG_PTR_HI) begin
				nxt_st.rdata = {4'h0, st_ff.mptr[11:8]};
			end else if (REG_ADDR_IN == `REG_MEM_DATA) begin
				nxt_st.rdata = mem_rdata; // Needs idle port the cycle before
			end else if (REG_ADDR_IN == `REG_PHASE) begin
				nxt_st.rdata = {3'h0, st_ff.phase};
			end
		end
		// Four-phase instruction sequence
		case (st_ff.phase)
			ilo_exec_pkg::PH_IDLE: begin
				if (INSTR_VALID_IN) begin
					nxt_st.instr = INSTR_IN;
					nxt_st.ready = 1'b0;
					nxt_st.phase = ilo_exec_pkg::PH_DECODE;
				end
			end
			ilo_exec_pkg::PH_DECODE: begin
				nxt_st.op = decode_op(st_ff.instr);
				nxt_st.indexed = is_indexed(st_ff.instr, ext_en);
				nxt_st.ea = eff_addr(st_ff.instr, ext_en, st_ff.sfp, st_ff.bank);
				nxt_st.phase = ilo_exec_pkg::PH_READ;
			end
			ilo_exec_pkg::PH_READ: begin
				nxt_st.phase = ilo_exec_pkg::PH_PROC;
			end
			ilo_exec_pkg::PH_PROC: begin
				nxt_st.operand = mem_rdata;
				nxt_st.result = alu_result;
				nxt_st.flags = alu_status;
				nxt_st.phase = ilo_exec_pkg::PH_WRITE;
			end
			ilo_exec_pkg::PH_WRITE: begin
				if (st_ff.op == ilo_exec_pkg::OP_ADD) begin
					nxt_st.status = st_ff.flags;
					if (!st_ff.instr[`D_BIT]) begin
						nxt_st.wreg = st_ff.result;
					end
				end
				nxt_st.done = 1'b1;
				nxt_st.ready = 1'b1;
				nxt_st.phase = ilo_exec_pkg::PH_IDLE;
			end
			default: begin
				nxt_st.ready = 1'b1;
				nxt_st.phase = ilo_exec_pkg::PH_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge CLK_SYS_IN) begin
		if (RESET_IN) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Every output straight from the state register
	assign REG_RDATA_OUT = st_ff.rdata;
	assign INSTR_READY_OUT = st_ff.ready;
	assign DONE_OUT = st_ff.done;
	assign W_OUT = st_ff.wreg;
	assign STATUS_OUT = st_ff.status;
	assign EXT_ENABLE_OUT = st_ff.cfg[`CFG_EXT_BIT];

	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (RESET_IN);

	// Indexed access reads at pointer plus offset
	a_idx_read_addr: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_READ && st_ff.indexed) |->
			mem_addr == st_ff.sfp + {4'h0, st_ff.instr[7:0]}
	) else $error("indexed read address wrong");

	// Set access bit or disabled extension never indexes
	a_literal_kept: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_DECODE &&
			(st_ff.instr[`A_BIT] || !ext_en)) |=> !st_ff.indexed
	) else $error("literal operand taken as offset");

	// Banked literal uses the bank selector
	a_bank_literal: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_DECODE && st_ff.instr[`A_BIT]) |=>
			st_ff.ea == {$past(st_ff.bank[3:0]), st_ff.instr[7:0]}
	) else $error("banked address wrong");

	// Sum is accumulator plus fetched byte
	a_add_sum: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_PROC && st_ff.op == ilo_exec_pkg::OP_ADD) |=>
			st_ff.result == 8'($past(st_ff.wreg) + $past(mem_rdata))
	) else $error("indexed add sum wrong");

	// d=0 loads the accumulator and spares the byte
	a_add_to_acc: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_WRITE && st_ff.op == ilo_exec_pkg::OP_ADD &&
			!st_ff.instr[`D_BIT]) |-> !mem_we ##1 st_ff.wreg == $past(st_ff.result)
	) else $error("add to accumulator wrong");

	// d=1 writes the sum back to the byte
	a_add_to_byte: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_WRITE && st_ff.op == ilo_exec_pkg::OP_ADD &&
			st_ff.instr[`D_BIT]) |-> mem_we && mem_addr == st_ff.ea &&
			mem_wdata == st_ff.result
	) else $error("add write-back wrong");

	// Bit set and fill leave the flags alone
	a_flags_kept: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_WRITE && st_ff.op != ilo_exec_pkg::OP_ADD &&
			!(REG_WR_IN && REG_ADDR_IN == `REG_STATUS)) |=> $stable(st_ff.status)
	) else $error("flags changed by bit set or fill");

	// Add decodes from its opcode
	a_add_decode: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_DECODE && st_ff.instr[15:10] == `OPC_ADD) |=>
			st_ff.op == ilo_exec_pkg::OP_ADD
	) else $error("add not decoded");

	// Bit set changes exactly bit b
	a_bit_only: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_WRITE && st_ff.op == ilo_exec_pkg::OP_BSET) |->
			mem_we && mem_wdata[st_ff.instr[11:9]] &&
			((mem_wdata ^ st_ff.operand) & ~(8'h01 << st_ff.instr[11:9])) == 8'h00
	) else $error("bit set altered other bits");

	// Bit set decodes from its opcode
	a_bset_decode: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_DECODE && st_ff.instr[15:12] == `OPC_BSET) |=>
			st_ff.op == ilo_exec_pkg::OP_BSET
	) else $error("bit set not decoded");

	// Fill stores all ones at the operand address
	a_fill_value: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_WRITE && st_ff.op == ilo_exec_pkg::OP_FILL) |->
			mem_we && mem_wdata == `FILL_VALUE && mem_addr == st_ff.ea
	) else $error("fill value wrong");

	// Fill decodes from its opcode
	a_fill_decode: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_DECODE && st_ff.instr[15:9] == `OPC_FILL) |=>
			st_ff.op == ilo_exec_pkg::OP_FILL
	) else $error("fill not decoded");

	// Disabled extension after reset
	a_ext_disabled: assert property (
		$fell(RESET_IN) |-> !EXT_ENABLE_OUT
	) else $error("extension enabled out of reset");

	// Accepted word finishes after four phases
	a_four_phases: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_IDLE && INSTR_VALID_IN) |=>
			(!INSTR_READY_OUT && !DONE_OUT) [*4] ##1 (DONE_OUT && INSTR_READY_OUT)
	) else $error("instruction cycle length wrong");

	// Done stands one cycle, beside ready
	a_done_pulse: assert property (
		DONE_OUT |-> INSTR_READY_OUT ##1 !DONE_OUT
	) else $error("done pulse wrong");

	// Small argument without extension stays a low literal
	a_low_literal: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_DECODE && !st_ff.instr[`A_BIT] && !ext_en &&
			st_ff.instr[7:0] <= `IDX_LIMIT) |=> st_ff.ea == {4'h0, st_ff.instr[7:0]}
	) else $error("low literal address wrong");

	// Argument above the limit is never an offset
	a_high_literal: assert property (
		(st_ff.phase == ilo_exec_pkg::PH_DECODE && !st_ff.instr[`A_BIT] &&
			st_ff.instr[7:0] > `IDX_LIMIT) |=> st_ff.ea == {`ACC_HIGH_BANK, st_ff.instr[7:0]}
	) else $error("high literal address wrong");

endmodule

/* File: tb/indexed_literal_offset_exec_bench.sv */
`timescale 1ns/1ps
`include "ilo_exec_defines.svh"

module indexed_literal_offset_exec_bench;
	logic        clk;
	logic        reset;
	logic [15:0] instr;
	logic        instr_valid;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        instr_ready;
	logic        done;
	logic [7:0]  w_val;
	logic [7:0]  status_val;
	logic        ext_en;
	int          err_count;
	int          checked;
	logic [7:0]  exp_byte;
	logic [7:0]  flag_tab [3][4];

	indexed_literal_offset_exec dut_u (
		.CLK_SYS_IN      (clk),
		.RESET_IN        (reset),
		.INSTR_IN        (instr),
		.INSTR_VALID_IN  (instr_valid),
		.REG_ADDR_IN     (reg_addr),
		.REG_WDATA_IN    (reg_wdata),
		.REG_WR_IN       (reg_wr),
		.REG_RD_IN       (reg_rd),
		.REG_RDATA_OUT   (reg_rdata),
		.INSTR_READY_OUT (instr_ready),
		.DONE_OUT        (done),
		.W_OUT           (w_val),
		.STATUS_OUT      (status_val),
		.EXT_ENABLE_OUT  (ext_en)
	);

	// Free-running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("Mismatches %0d of %0d comparisons", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One-cycle write strobe; a gap cycle follows so strobes never collide
	task automatic reg_wr_t(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd_t(input logic [3:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		chk(name, reg_rdata, exp);
	endtask

	task automatic set_ptr(input logic [3:0] lo, input logic [11:0] v);
		reg_wr_t(lo, v[7:0]);
		reg_wr_t(lo + 4'h1, {4'h0, v[11:8]});
	endtask

	task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
		set_ptr(`REG_PTR_LO, a);
		reg_wr_t(`REG_MEM_DATA, d);
	endtask

	// Extra idle edge keeps the pointer steady before the read strobe
	task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
		set_ptr(`REG_PTR_LO, a);
		@(posedge clk);
		reg_rd_t(`REG_MEM_DATA, exp, "mem_byte");
	endtask

	// Issue one word; optionally offer a second word while busy, which must be ignored
	task automatic exec(input logic [15:0] w, input bit poke, input logic [15:0] junk);
		int n;
		bit busy_ok;
		n = 0;
		busy_ok = 1'b1;
		@(posedge clk);
		instr       <= w;
		instr_valid <= 1'b1;
		@(posedge clk);
		instr_valid <= 1'b0;
		while (n < 10) begin
			@(posedge clk);
			n++;
			if (poke && n == 2) begin
				instr       <= junk;
				instr_valid <= 1'b1;
			end
			if (n == 3) begin
				instr_valid <= 1'b0;
			end
			#1;
			if (done === 1'b1) begin
				break;
			end
			if (instr_ready !== 1'b0) begin
				busy_ok = 1'b0;
			end
		end
		// Take edge not counted: one edge each for decode, read, process, write
		chk("done_delay", 16'(n), 16'(`INSTR_PHASES));
		chk("ready_busy", busy_ok, 1'b1);
		chk("ready_back", instr_ready, 1'b1);
		@(posedge clk);
		#1;
		chk("done_pulse", done, 1'b0);
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#100000;
		err_count++;
		stop_test();
	end

	initial begin
		err_count   = 0;
		checked     = 0;
		reset       = 1'b1;
		instr       = 16'h0000;
		instr_valid = 1'b0;
		reg_addr    = 4'h0;
		reg_wdata   = 8'h00;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		// W, memory byte, expected sum, expected flags
		flag_tab[0] = '{8'h80, 8'h80, 8'h00, 8'h0d};
		flag_tab[1] = '{8'h7f, 8'h01, 8'h80, 8'h1a};
		flag_tab[2] = '{8'h0f, 8'h01, 8'h10, 8'h02};
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("w_reset", w_val, 8'h00);
		chk("status_reset", status_val, 8'h00);
		chk("ext_reset", ext_en, 1'b0);
		chk("ready_reset", instr_ready, 1'b1);
		reg_rd_t(`REG_CFG, `CFG_RST, "cfg_reset");
		reg_rd_t(`REG_PHASE, 8'h01, "phase_idle");
		reg_wr_t(4'hc, 8'h5a);
		reg_rd_t(4'hc, 8'h00, "unmapped");
		// Only bit 0 of the configuration byte may enable the extension
		reg_wr_t(`REG_CFG, 8'hfe);
		#1;
		chk("ext_mask", ext_en, 1'b0);
		// Extension off: a=0 operand stays a literal low address
		set_ptr(`REG_SFP_LO, 12'ha00);
		reg_rd_t(`REG_SFP_HI, 8'h0a, "sfp_hi");
		mem_wr(12'h010, 8'h00);
		mem_wr(12'ha10, 8'h00);
		exec(16'h6810, 1'b0, 16'h0000);
		mem_chk(12'h010, 8'hff);
		mem_chk(12'ha10, 8'h00);
		reg_wr_t(`REG_CFG, 8'h01);
		#1;
		chk("ext_on", ext_en, 1'b1);
		// Indexed add into W
		mem_wr(12'ha2c, 8'h20);
		reg_wr_t(`REG_WREG, 8'h17);
		exec(16'h242c, 1'b0, 16'h0000);
		chk("add_w", w_val, 8'h37);
		chk("add_flags", status_val, 8'h00);
		reg_rd_t(`REG_WREG, 8'h37, "wreg_reg");
		mem_chk(12'ha2c, 8'h20);
		// Indexed add back into the byte, flag corner cases
		for (int i = 0; i < 3; i++) begin
			reg_wr_t(`REG_WREG, flag_tab[i][0]);
			mem_wr(12'ha2c, flag_tab[i][1]);
			exec(16'h262c, 1'b0, 16'h0000);
			chk("add_keep_w", w_val, flag_tab[i][0]);
			chk("add_status", status_val, flag_tab[i][3]);
			mem_chk(12'ha2c, flag_tab[i][2]);
		end
		// Bit set on every bit number, flags must hold
		reg_wr_t(`REG_STATUS, 8'h15);
		mem_wr(12'ha0a, 8'h00);
		exp_byte = 8'h00;
		for (int b = 0; b < 8; b++) begin
			exec({4'h8, 3'(b), 1'b0, 8'h0a}, 1'b0, 16'h0000);
			exp_byte = exp_byte | (8'h01 << b);
			mem_chk(12'ha0a, exp_byte);
		end
		chk("bset_flags", status_val, 8'h15);
		// Fill at the last indexed offset and the first literal one
		mem_wr(12'ha5f, 8'h00);
		mem_wr(12'hf60, 8'h00);
		mem_wr(12'ha60, 8'h00);
		exec(16'h685f, 1'b0, 16'h0000);
		mem_chk(12'ha5f, `FILL_VALUE);
		exec(16'h6860, 1'b0, 16'h0000);
		mem_chk(12'hf60, 8'hff);
		mem_chk(12'ha60, 8'h00);
		chk("fill_flags", status_val, 8'h15);
		// Unknown word still runs a full cycle and leaves the flags alone
		exec(16'h0000, 1'b0, 16'h0000);
		chk("none_flags", status_val, 8'h15);
		reg_rd_t(`REG_STATUS, 8'h15, "status_reg");
		// Access bit set: banked literal even with extension on
		reg_wr_t(`REG_BANK, 8'h02);
		reg_rd_t(`REG_BANK, 8'h02, "bank_reg");
		mem_wr(12'h230, 8'h00);
		mem_wr(12'ha30, 8'h00);
		exec(16'h6930, 1'b0, 16'h0000);
		mem_chk(12'h230, 8'hff);
		mem_chk(12'ha30, 8'h00);
		// A word offered while busy is dropped, not queued
		mem_wr(12'ha31, 8'h00);
		mem_wr(12'ha32, 8'h00);
		exec(16'h6832, 1'b1, 16'h6831);
		repeat (6) @(posedge clk);
		mem_chk(12'ha32, 8'hff);
		mem_chk(12'ha31, 8'h00);
		stop_test();
	end
endmodule
